// >>> core/pief_pkg.sv
// Package: register map, field positions and carriers of the irq flag block
`default_nettype none

package pief_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_EN_ONE = 3'h1;
  localparam logic [2:0] ADDR_EN_TWO = 3'h2;
  localparam logic [2:0] ADDR_EN_THREE = 3'h3;
  localparam logic [2:0] ADDR_REQ_ONE = 3'h4;
  localparam logic [2:0] ADDR_REQ_TWO = 3'h5;
  localparam logic [2:0] ADDR_REQ_THREE = 3'h6;

  // Main control register fields
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPH_IRQ_ENABLE_BIT = 6;

  // Enable and request field positions (shared by matching pairs)
  localparam int TIMER1_GATE_BIT = 7;
  localparam int ADC_DONE_BIT = 6;
  localparam int TIMER2_MATCH_BIT = 1;
  localparam int TIMER1_OVERFLOW_BIT = 0;
  localparam int OSC_OVERFLOW_BIT = 2;
  localparam int LOGIC_CELL_B_BIT = 1;
  localparam int LOGIC_CELL_A_BIT = 0;

  // Implemented-bit masks; all other positions read as zero
  localparam logic [7:0] MASK_CTRL = 8'hC0;
  localparam logic [7:0] MASK_ONE = 8'hC3;
  localparam logic [7:0] MASK_TWO = 8'h04;
  localparam logic [7:0] MASK_THREE = 8'h03;

  // Value after every reset
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Register port request from software
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pief_bus_type;

  // One-cycle event strobes from the peripherals
  typedef struct packed {
    logic timer1_gate;
    logic adc_done;
    logic timer2_match;
    logic timer1_overflow;
    logic osc_overflow;
    logic logic_cell_b;
    logic logic_cell_a;
  } pief_evt_type;

endpackage : pief_pkg

`default_nettype wire

// >>> core/pief_irq_flags.sv
// Peripheral interrupt enable and request-flag registers
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module pief_irq_flags
  import pief_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire pief_bus_type bus_in,
  input wire pief_evt_type evt_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic periph_irq_out
);

  // The register map is fixed at eight bits per register
  if (DATA_W != 8)
  begin : g_bad_width
    $error("DATA_W must be 8");
  end

  // Register state
  logic [7:0] ctrl_r;
  logic [7:0] en_one_r;
  logic [7:0] en_two_r;
  logic [7:0] en_three_r;
  logic [7:0] req_one_r;
  logic [7:0] req_two_r;
  logic [7:0] req_three_r;
  logic [7:0] rd_data_r;
  logic irq_r;

  // Next values
  logic [7:0] req_one_nxt;
  logic [7:0] req_two_nxt;
  logic [7:0] req_three_nxt;
  logic [7:0] rd_data_nxt;
  logic irq_nxt;

  // Address decode
  wire wr_ctrl = bus_in.wr && (bus_in.addr == ADDR_CTRL);
  wire wr_en_one = bus_in.wr && (bus_in.addr == ADDR_EN_ONE);
  wire wr_en_two = bus_in.wr && (bus_in.addr == ADDR_EN_TWO);
  wire wr_en_three = bus_in.wr && (bus_in.addr == ADDR_EN_THREE);
  wire wr_req_one = bus_in.wr && (bus_in.addr == ADDR_REQ_ONE);
  wire wr_req_two = bus_in.wr && (bus_in.addr == ADDR_REQ_TWO);
  wire wr_req_three = bus_in.wr && (bus_in.addr == ADDR_REQ_THREE);

  // Event strobes placed at their flag positions
  wire [7:0] set_one;
  wire [7:0] set_two;
  wire [7:0] set_three;

  assign set_one = ({7'h00, evt_in.timer1_gate} << TIMER1_GATE_BIT)
    | ({7'h00, evt_in.adc_done} << ADC_DONE_BIT)
    | ({7'h00, evt_in.timer2_match} << TIMER2_MATCH_BIT)
    | ({7'h00, evt_in.timer1_overflow} << TIMER1_OVERFLOW_BIT);
  assign set_two =
    {7'h00, evt_in.osc_overflow} << OSC_OVERFLOW_BIT;
  assign set_three = ({7'h00, evt_in.logic_cell_b} << LOGIC_CELL_B_BIT)
    | ({7'h00, evt_in.logic_cell_a} << LOGIC_CELL_A_BIT);

  // Flag update: software value first, event ORed last so it wins
  assign req_one_nxt = ((wr_req_one ? bus_in.wdata : req_one_r)
    | set_one) & MASK_ONE;
  assign req_two_nxt = ((wr_req_two ? bus_in.wdata : req_two_r)
    | set_two) & MASK_TWO;
  assign req_three_nxt = ((wr_req_three ? bus_in.wdata : req_three_r)
    | set_three) & MASK_THREE;

  // Pending sources, each flag paired with its own enable
  wire [7:0] pend_one = req_one_r & en_one_r;
  wire [7:0] pend_two = req_two_r & en_two_r;
  wire [7:0] pend_three = req_three_r & en_three_r;
  wire any_pend = |{pend_one, pend_two, pend_three};
  wire global_en = ctrl_r[GLOBAL_IRQ_ENABLE_BIT];
  wire periph_en = ctrl_r[PERIPH_IRQ_ENABLE_BIT];

  // Peripheral request to the core; both enables must be set
  assign irq_nxt = global_en && periph_en && any_pend;

  // Read mux; unmapped addresses and reserved bits return zero
  wire [7:0] rd_sel =
    (bus_in.addr == ADDR_CTRL) ? ctrl_r :
    (bus_in.addr == ADDR_EN_ONE) ? en_one_r :
    (bus_in.addr == ADDR_EN_TWO) ? en_two_r :
    (bus_in.addr == ADDR_EN_THREE) ? en_three_r :
    (bus_in.addr == ADDR_REQ_ONE) ? req_one_r :
    (bus_in.addr == ADDR_REQ_TWO) ? req_two_r :
    (bus_in.addr == ADDR_REQ_THREE) ? req_three_r :
    RESET_VALUE;

  // Read data stands only in the cycle after the strobe
  assign rd_data_nxt = bus_in.rd ? rd_sel : RESET_VALUE;

  // Control and enable registers, stored through their masks
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_r <= RESET_VALUE;
      en_one_r <= RESET_VALUE;
      en_two_r <= RESET_VALUE;
      en_three_r <= RESET_VALUE;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= bus_in.wdata & MASK_CTRL;
      if (wr_en_one)
        en_one_r <= bus_in.wdata & MASK_ONE;
      if (wr_en_two)
        en_two_r <= bus_in.wdata & MASK_TWO;
      if (wr_en_three)
        en_three_r <= bus_in.wdata & MASK_THREE;
    end
  end

  // Request flags; a stale flag fires at once when its enable is set
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      req_one_r <= RESET_VALUE;
      req_two_r <= RESET_VALUE;
      req_three_r <= RESET_VALUE;
    end
    else
    begin
      req_one_r <= req_one_nxt;
      req_two_r <= req_two_nxt;
      req_three_r <= req_three_nxt;
    end
  end

  // Registered outputs cost one cycle of latency but never glitch
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rd_data_r <= RESET_VALUE;
      irq_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign periph_irq_out = irq_r;

  // Checks on the block's own behaviour
  wire [23:0] req_all = {req_three_r, req_two_r, req_one_r};
  wire [23:0] set_all = {set_three, set_two, set_one};

  property p_periph_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
    !ctrl_r[PERIPH_IRQ_ENABLE_BIT] |=> !periph_irq_out;
  endproperty
  a_periph_gate: assert property (p_periph_gate)
    else $error("irq raised with peripheral enable clear");

  property p_event_sets;
    @(posedge ref_clk_in) disable iff (rst_in)
    (set_all != 24'h00_0000) |=>
      ((req_all & $past(set_all)) == $past(set_all));
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event did not set its flag");

  property p_en_two_field;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_en_two |=> (en_two_r == ($past(bus_in.wdata) & 8'h04));
  endproperty
  a_en_two_field: assert property (p_en_two_field)
    else $error("second enable register holds wrong bits");

  property p_en_three_field;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_en_three |=> (en_three_r == ($past(bus_in.wdata) & 8'h03));
  endproperty
  a_en_three_field: assert property (p_en_three_field)
    else $error("third enable register holds wrong bits");

  property p_req_one_map;
    @(posedge ref_clk_in) disable iff (rst_in)
    evt_in.timer1_gate && evt_in.timer1_overflow |=>
      req_one_r[7] && req_one_r[0];
  endproperty
  a_req_one_map: assert property (p_req_one_map)
    else $error("timer1 flags not at bits 7 and 0");

  property p_req_two_map;
    @(posedge ref_clk_in) disable iff (rst_in)
    evt_in.osc_overflow |=> req_two_r[2] ##1 (req_two_r[2]
      || $past(wr_req_two));
  endproperty
  a_req_two_map: assert property (p_req_two_map)
    else $error("oscillator flag not held at bit 2");

  property p_req_three_map;
    @(posedge ref_clk_in) disable iff (rst_in)
    evt_in.logic_cell_b |=> req_three_r[1];
  endproperty
  a_req_three_map: assert property (p_req_three_map)
    else $error("logic cell b flag not at bit 1");

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    $past(bus_in.rd) && ($past(bus_in.addr) == ADDR_REQ_ONE)
      |-> ((rd_data_out & 8'h3C) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved request bits read nonzero");

  property p_reset_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
    $fell(rst_in) |-> (req_all == 24'h00_0000) && (ctrl_r == 8'h00)
      && !periph_irq_out;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  property p_en_one_field;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_en_one |=> (en_one_r == ($past(bus_in.wdata) & 8'hC3));
  endproperty
  a_en_one_field: assert property (p_en_one_field)
    else $error("first enable register holds wrong bits");

  property p_global_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
    !ctrl_r[GLOBAL_IRQ_ENABLE_BIT] |=> !periph_irq_out;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("irq raised with global enable clear");

  property p_irq_cause;
    @(posedge ref_clk_in) disable iff (rst_in)
    (global_en && periph_en && ((req_one_r & en_one_r) != 8'h00))
      |=> periph_irq_out;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("pending enabled flag raised no irq");

  property p_event_wins;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_req_one && (bus_in.wdata == 8'h00) && evt_in.adc_done
      |=> req_one_r[6] && (req_one_r[7] == $past(evt_in.timer1_gate));
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("clearing write lost a coincident event");

  property p_irq_cause_two;
    @(posedge ref_clk_in) disable iff (rst_in)
    (global_en && periph_en && ((req_two_r & en_two_r) != 8'h00))
      |=> periph_irq_out;
  endproperty
  a_irq_cause_two: assert property (p_irq_cause_two)
    else $error("pending oscillator flag raised no irq");

  property p_irq_cause_three;
    @(posedge ref_clk_in) disable iff (rst_in)
    (global_en && periph_en && ((req_three_r & en_three_r) != 8'h00))
      |=> periph_irq_out;
  endproperty
  a_irq_cause_three: assert property (p_irq_cause_three)
    else $error("pending logic cell flag raised no irq");

  property p_irq_needs_both;
    @(posedge ref_clk_in) disable iff (rst_in)
    periph_irq_out |-> (($past(ctrl_r) & 8'hC0) == 8'hC0);
  endproperty
  a_irq_needs_both: assert property (p_irq_needs_both)
    else $error("irq raised without both enables");

  property p_rd_idle_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    !bus_in.rd |=> (rd_data_out == 8'h00);
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data stood beyond one cycle");

  property p_reserved_state;
    @(posedge ref_clk_in) disable iff (rst_in)
    ((req_one_r & 8'h3C) == 8'h00) && ((req_two_r & 8'hFB) == 8'h00)
      && ((req_three_r & 8'hFC) == 8'h00) && ((en_one_r & 8'h3C) == 8'h00)
      && ((en_two_r & 8'hFB) == 8'h00) && ((en_three_r & 8'hFC) == 8'h00);
  endproperty
  a_reserved_state: assert property (p_reserved_state)
    else $error("reserved bit stored a one");

  property p_ctrl_field;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_ctrl |=> (ctrl_r == ($past(bus_in.wdata) & 8'hC0));
  endproperty
  a_ctrl_field: assert property (p_ctrl_field)
    else $error("control register holds wrong bits");

  property p_write_three;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_req_three && !evt_in.logic_cell_a && !evt_in.logic_cell_b
      |=> (req_three_r == ($past(bus_in.wdata) & 8'h03));
  endproperty
  a_write_three: assert property (p_write_three)
    else $error("third request register ignored a write");

  property p_rd_en_two;
    @(posedge ref_clk_in) disable iff (rst_in)
    bus_in.rd && (bus_in.addr == ADDR_EN_TWO)
      |=> (rd_data_out == $past(en_two_r));
  endproperty
  a_rd_en_two: assert property (p_rd_en_two)
    else $error("second enable register read back wrong");

  property p_flag_holds;
    @(posedge ref_clk_in) disable iff (rst_in)
    !wr_req_one && (set_one == 8'h00) |=> $stable(req_one_r);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("first request register changed unprompted");

  property p_reset_enables;
    @(posedge ref_clk_in) disable iff (rst_in)
    $fell(rst_in) |-> (en_one_r == 8'h00) && (en_two_r == 8'h00)
      && (en_three_r == 8'h00) && (rd_data_out == 8'h00);
  endproperty
  a_reset_enables: assert property (p_reset_enables)
    else $error("enables or read data not cleared by reset");

endmodule : pief_irq_flags

`default_nettype wire

// >>> bench/pief_evt_src.sv
// Peripheral event source model feeding one-cycle strobes to the flags
`timescale 1ns/10ps
`default_nettype none

module pief_evt_src
  import pief_pkg::*;
(
  input wire logic [6:0] fire_in,
  output var pief_evt_type evt_out
);
  // Sources pulse on the system clock; the bench holds a strobe one cycle
  // so each high cycle is exactly one event, never a stretched level
  assign evt_out = pief_evt_type'(fire_in);
endmodule : pief_evt_src

`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench: register model against the irq flag block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import pief_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  pief_bus_type bus = '0;
  logic [6:0] fire = 7'h00;
  pief_evt_type evt;
  logic [7:0] rd_data_out;
  logic periph_irq_out;
  logic [7:0] m [8];
  logic [7:0] msk [8];
  logic [31:0] x = 32'hb7b8_05c8;
  int bad_count = 0;
  int n_compared = 0;

  pief_irq_flags #(.DATA_W(8)) u_pief_irq_flags (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .bus_in(bus),
    .evt_in(evt),
    .rd_data_out(rd_data_out),
    .periph_irq_out(periph_irq_out)
  );

  pief_evt_src u_pief_evt_src (
    .fire_in(fire),
    .evt_out(evt)
  );

  // 25 MHz system clock
  always #20 ref_clk_in = ~ref_clk_in;

  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction : lfsr

  // Model request: global and peripheral enable gate any enabled flag
  function automatic logic [7:0] irq_exp();
    irq_exp = {7'h00, m[0][7] & m[0][6] &
      (|((m[1] & m[4]) | (m[2] & m[5]) | (m[3] & m[6])))};
  endfunction : irq_exp

  // Synchronous reset held six edges; model returns to all zero
  task automatic do_reset;
    // A mid-run reset starts on a rising edge like every other input
    if (!rst_in) @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    foreach (m[i]) m[i] = 8'h00;
  endtask : do_reset

  // One bus cycle with optional coincident events, then output checks
  task automatic op(input logic w, input logic r, input logic [2:0] a,
                    input logic [7:0] d, input logic [6:0] f);
    @(posedge ref_clk_in);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    fire <= f;
    @(posedge ref_clk_in);
    bus <= '0;
    fire <= 7'h00;
    #1;
    if (r) chk(rd_data_out, m[a]);
    if (w) m[a] = d & msk[a];
    // Event applied after the write so a clearing write never wins
    m[4] |= {f[6], f[5], 4'h0, f[4], f[3]};
    m[5] |= {5'h00, f[2], 2'h0};
    m[6] |= {6'h00, f[1], f[0]};
    @(posedge ref_clk_in);
    #1;
    chk(rd_data_out, 8'h00);
    chk({7'h00, periph_irq_out}, irq_exp());
  endtask : op

  // Reset values of every index, the unmapped one included
  task automatic read_all;
    for (int i = 0; i < 8; i++) op(1'b0, 1'b1, i[2:0], 8'h00, 7'h00);
  endtask : read_all

  // Watchdog sized well above the roughly two thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    tally_and_finish();
  end

  // Main sequence: reset, stale-flag clearing, random traffic, reset again
  initial
  begin
    msk = '{MASK_CTRL, MASK_ONE, MASK_TWO, MASK_THREE,
            MASK_ONE, MASK_TWO, MASK_THREE, 8'h00};
    do_reset();
    read_all();
    op(1'b0, 1'b0, ADDR_CTRL, 8'h00, 7'h7f);
    op(1'b1, 1'b0, ADDR_REQ_ONE, 8'h00, 7'h00);
    op(1'b1, 1'b0, ADDR_EN_ONE, 8'hff, 7'h00);
    op(1'b1, 1'b0, ADDR_CTRL, 8'hff, 7'h00);
    repeat (600)
    begin
      x = lfsr(x);
      case (x[1:0])
        2'd0: op(1'b1, 1'b0, x[4:2], x[12:5], x[19:13]);
        2'd1: op(1'b0, 1'b1, x[4:2], 8'h00, 7'h00);
        2'd2: op(1'b0, 1'b0, 3'h0, 8'h00, x[19:13] & x[26:20]);
        default: op(1'b1, 1'b0, (x[3:2] == 2'd3) ? 3'h4 : 3'h4 + x[4:2] % 3,
                    8'h00, x[19:13]);
      endcase
    end
    do_reset();
    read_all();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
